// [verilog/pcs_pkg.sv]
// Shared constants and carrier types for the pressure compensation scheduler.
// Assumes a single 20 MHz clock; pressures are unsigned counts of 0.1 psi.
`default_nettype none

package pcs_pkg;

  // Clock and time base.
  localparam int unsigned PCS_CLK_HZ = 20_000_000;
  localparam int unsigned PCS_MINUTE_S = 60;
  localparam int unsigned PCS_CYC_PER_MIN = PCS_CLK_HZ * PCS_MINUTE_S;
  localparam int unsigned PCS_TICK_W = 31;
  localparam logic [5:0] PCS_MIN_PER_HOUR = 6'h3C;
  localparam logic [15:0] PCS_MIN_PER_HOUR_W = 16'h003C;

  // Storage shape.
  localparam int unsigned PCS_NUM_RECIPES = 6;
  localparam logic [2:0] PCS_RECIPE_LIMIT = 3'h6;
  localparam int unsigned PCS_MAX_STEPS = 12;
  localparam logic [3:0] PCS_STEP_FIRST = 4'h1;
  localparam logic [3:0] PCS_STEP_LAST = 4'hC;
  localparam logic [7:0] PCS_STEP_LAST_W = 8'h0C;

  // Reset values.
  localparam logic [15:0] PCS_PRES_RST = 16'h0000;
  localparam logic [7:0] PCS_HOURS_RST = 8'h00;

  typedef logic [15:0] pcs_pres_type;
  typedef logic [2:0] pcs_recipe_type;
  typedef logic [3:0] pcs_hour_type;

  typedef enum logic {PCS_MODE_LINEAR, PCS_MODE_STEPS} pcs_mode_type;

  typedef enum logic [2:0] {
    PCS_FLD_MODE,
    PCS_FLD_MIN,
    PCS_FLD_MAX,
    PCS_FLD_HOURS,
    PCS_FLD_INC,
    PCS_FLD_SAVE
  } pcs_field_type;

  // One operator panel write.
  typedef struct packed {
    pcs_recipe_type recipe;
    pcs_field_type field;
    pcs_hour_type hour;
    pcs_pres_type value;
  } pcs_cfg_type;

  // Live compensation status as shown on the home screen.
  typedef struct packed {
    logic on;
    pcs_mode_type mode;
    logic [7:0] hours;
    pcs_pres_type setpoint;
  } pcs_status_type;

  // Stored program of one recipe, in its selected mode.
  typedef struct packed {
    pcs_mode_type mode;
    pcs_pres_type min;
    pcs_pres_type max;
    logic [7:0] hours;
    pcs_pres_type inc;
    logic saved;
  } pcs_view_type;

  // Adds an increase and saturates at the ceiling.
  function automatic pcs_pres_type pcs_sat_add(input pcs_pres_type base,
                                               input pcs_pres_type inc,
                                               input pcs_pres_type ceil);
    logic [16:0] sum;
    sum = {1'b0, base} + {1'b0, inc};
    if (sum >= {1'b0, ceil}) begin
      return ceil;
    end
    return sum[15:0];
  endfunction : pcs_sat_add

endpackage : pcs_pkg

`default_nettype wire

// [verilog/pcs_tick_gen.sv]
// Minute tick divider for the pressure compensation scheduler.
// Assumes one free running clock; clear restarts a full minute.
`timescale 1ns/1ns
`default_nettype none

module pcs_tick_gen #(
  parameter int unsigned CYC_PER_MIN = pcs_pkg::PCS_CYC_PER_MIN
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Control.
  input wire logic enable_in,
  input wire logic clear_in,
  // One-cycle minute pulse.
  output logic tick_out
);
  import pcs_pkg::*;

  localparam logic [PCS_TICK_W-1:0] LAST = PCS_TICK_W'(CYC_PER_MIN - 1);

  logic [PCS_TICK_W-1:0] count_q;

  // Counting only while enabled keeps every minute whole after a start.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in || clear_in || !enable_in) begin
      count_q <= '0;
      tick_out <= 1'b0;
    end else if (count_q == LAST) begin
      count_q <= '0;
      tick_out <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : pcs_tick_gen

`default_nettype wire

// [verilog/pcs_scheduler.sv]
// Fluid pressure compensation scheduler: per recipe programs, ramp and step engine.
// Assumes panel inputs are synchronous to ref_clk_in and pulses last one cycle.
`timescale 1ns/1ns
`default_nettype none

module pcs_scheduler #(
  parameter int unsigned CYC_PER_MIN = pcs_pkg::PCS_CYC_PER_MIN
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Panel program writes.
  input wire logic cfg_wr_in,
  input wire pcs_pkg::pcs_cfg_type cfg_in,
  // Start and stop commands.
  input wire logic start_in,
  input wire logic stop_in,
  input wire pcs_pkg::pcs_recipe_type run_recipe_in,
  // Program read back.
  input wire pcs_pkg::pcs_recipe_type rd_recipe_in,
  input wire pcs_pkg::pcs_hour_type rd_hour_in,
  // Status and display.
  output pcs_pkg::pcs_status_type status_out,
  output pcs_pkg::pcs_view_type view_out,
  output logic refresh_out
);
  import pcs_pkg::*;

  // Program storage, one set per mode and recipe.
  pcs_mode_type mode_q [PCS_NUM_RECIPES];
  pcs_pres_type lin_min_q [PCS_NUM_RECIPES];
  pcs_pres_type lin_max_q [PCS_NUM_RECIPES];
  logic [7:0] lin_hrs_q [PCS_NUM_RECIPES];
  logic lin_saved_q [PCS_NUM_RECIPES];
  pcs_pres_type stp_min_q [PCS_NUM_RECIPES];
  pcs_pres_type stp_max_q [PCS_NUM_RECIPES];
  logic stp_saved_q [PCS_NUM_RECIPES];
  pcs_pres_type stp_inc_q [PCS_NUM_RECIPES][PCS_MAX_STEPS];

  // Running program snapshot and timers.
  pcs_status_type status_q;
  pcs_recipe_type run_rec_q;
  pcs_pres_type run_min_q;
  pcs_pres_type run_max_q;
  logic [15:0] run_dur_q;
  logic [15:0] mins_q;
  logic [5:0] mih_q;
  pcs_view_type view_q;
  logic refresh_q;

  logic tick;
  logic start_ok;
  logic hour_done;
  logic [15:0] mins_nxt;
  pcs_mode_type sel_mode;
  pcs_pres_type sel_min;
  pcs_pres_type sel_max;
  logic [15:0] sel_dur;
  logic sel_saved;
  pcs_pres_type cur_inc;
  pcs_pres_type sp_d;
  logic [31:0] ramp;

  assign status_out = status_q;
  assign view_out = view_q;
  assign refresh_out = refresh_q;

  pcs_tick_gen #(.CYC_PER_MIN(CYC_PER_MIN)) u_tick (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(status_q.on),
    .clear_in(start_ok),
    .tick_out(tick)
  );

  // Minimum, maximum and save writes land in the set of the mode the recipe currently shows.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      for (int r = 0; r < PCS_NUM_RECIPES; r++) begin
        mode_q[r] <= PCS_MODE_LINEAR;
        lin_min_q[r] <= PCS_PRES_RST;
        lin_max_q[r] <= PCS_PRES_RST;
        lin_hrs_q[r] <= PCS_HOURS_RST;
        lin_saved_q[r] <= 1'b0;
        stp_min_q[r] <= PCS_PRES_RST;
        stp_max_q[r] <= PCS_PRES_RST;
        stp_saved_q[r] <= 1'b0;
        for (int h = 0; h < PCS_MAX_STEPS; h++) begin
          stp_inc_q[r][h] <= PCS_PRES_RST;
        end
      end
    end else if (cfg_wr_in && cfg_in.recipe < PCS_RECIPE_LIMIT) begin
      case (cfg_in.field)
        PCS_FLD_MODE: begin
          mode_q[cfg_in.recipe] <= pcs_mode_type'(cfg_in.value[0]);
        end
        PCS_FLD_MIN: begin
          if (mode_q[cfg_in.recipe] == PCS_MODE_LINEAR) begin
            lin_min_q[cfg_in.recipe] <= cfg_in.value;
          end else begin
            stp_min_q[cfg_in.recipe] <= cfg_in.value;
          end
        end
        PCS_FLD_MAX: begin
          if (mode_q[cfg_in.recipe] == PCS_MODE_LINEAR) begin
            lin_max_q[cfg_in.recipe] <= cfg_in.value;
          end else begin
            stp_max_q[cfg_in.recipe] <= cfg_in.value;
          end
        end
        PCS_FLD_HOURS: begin
          lin_hrs_q[cfg_in.recipe] <= cfg_in.value[7:0];
        end
        PCS_FLD_INC: begin
          // Hour indices outside one to twelve are dropped silently.
          if (cfg_in.hour >= PCS_STEP_FIRST && cfg_in.hour <= PCS_STEP_LAST) begin
            stp_inc_q[cfg_in.recipe][cfg_in.hour - PCS_STEP_FIRST] <= cfg_in.value;
          end
        end
        PCS_FLD_SAVE: begin
          if (mode_q[cfg_in.recipe] == PCS_MODE_LINEAR) begin
            lin_saved_q[cfg_in.recipe] <= 1'b1;
          end else begin
            stp_saved_q[cfg_in.recipe] <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Program chosen for a start; an empty or inverted span cannot be run.
  always_comb begin
    sel_mode = PCS_MODE_LINEAR;
    sel_min = PCS_PRES_RST;
    sel_max = PCS_PRES_RST;
    sel_dur = '0;
    sel_saved = 1'b0;
    if (run_recipe_in < PCS_RECIPE_LIMIT) begin
      sel_mode = mode_q[run_recipe_in];
      if (sel_mode == PCS_MODE_LINEAR) begin
        sel_min = lin_min_q[run_recipe_in];
        sel_max = lin_max_q[run_recipe_in];
        sel_dur = 16'(lin_hrs_q[run_recipe_in] * PCS_MIN_PER_HOUR_W);
        sel_saved = lin_saved_q[run_recipe_in] && lin_hrs_q[run_recipe_in] != '0;
      end else begin
        sel_min = stp_min_q[run_recipe_in];
        sel_max = stp_max_q[run_recipe_in];
        sel_saved = stp_saved_q[run_recipe_in];
      end
    end
  end

  assign start_ok = start_in && !status_q.on && sel_saved && sel_max > sel_min;

  // Next setpoint, evaluated for the coming minute tick.
  assign mins_nxt = mins_q + 16'h0001;
  assign hour_done = mih_q == PCS_MIN_PER_HOUR - 6'h01;
  assign ramp = 32'(run_max_q - run_min_q) * 32'(mins_nxt) / 32'(run_dur_q);

  always_comb begin
    cur_inc = PCS_PRES_RST;
    if (status_q.hours < PCS_STEP_LAST_W) begin
      cur_inc = stp_inc_q[run_rec_q][status_q.hours[3:0]];
    end
    sp_d = status_q.setpoint;
    if (status_q.mode == PCS_MODE_LINEAR) begin
      if (mins_nxt >= run_dur_q) begin
        sp_d = run_max_q;
      end else begin
        sp_d = pcs_sat_add(run_min_q, ramp[15:0], run_max_q);
      end
    end else if (hour_done && status_q.hours < PCS_STEP_LAST_W) begin
      sp_d = pcs_sat_add(status_q.setpoint, cur_inc, run_max_q);
    end
  end

  // Run control: start, operator stop, and the once a minute update.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      status_q <= '0;
      run_rec_q <= '0;
      run_min_q <= PCS_PRES_RST;
      run_max_q <= PCS_PRES_RST;
      run_dur_q <= '0;
      mins_q <= '0;
      mih_q <= '0;
    end else if (start_ok) begin
      status_q.on <= 1'b1;
      status_q.mode <= sel_mode;
      status_q.hours <= PCS_HOURS_RST;
      status_q.setpoint <= sel_min;
      run_rec_q <= run_recipe_in;
      run_min_q <= sel_min;
      run_max_q <= sel_max;
      run_dur_q <= sel_dur;
      mins_q <= '0;
      mih_q <= '0;
    end else if (stop_in && status_q.on) begin
      status_q.on <= 1'b0;
      status_q.hours <= PCS_HOURS_RST;
    end else if (status_q.on && tick) begin
      mins_q <= mins_nxt;
      mih_q <= hour_done ? '0 : mih_q + 6'h01;
      if (hour_done && status_q.hours != '1) begin
        status_q.hours <= status_q.hours + 8'h01;
      end
      status_q.setpoint <= sp_d;
      // Switching off once sp_d reaches maximum is what keeps the setpoint there.
      if (sp_d >= run_max_q) begin
        status_q.on <= 1'b0;
      end
    end
  end

  // Display refresh strobe marks each minute update while running.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      refresh_q <= 1'b0;
    end else begin
      refresh_q <= status_q.on && tick && !start_ok && !stop_in;
    end
  end

  // Read back of the selected recipe in its selected mode.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      view_q <= '0;
    end else if (rd_recipe_in < PCS_RECIPE_LIMIT) begin
      view_q.mode <= mode_q[rd_recipe_in];
      view_q.hours <= lin_hrs_q[rd_recipe_in];
      view_q.inc <= PCS_PRES_RST;
      if (rd_hour_in >= PCS_STEP_FIRST && rd_hour_in <= PCS_STEP_LAST) begin
        view_q.inc <= stp_inc_q[rd_recipe_in][rd_hour_in - PCS_STEP_FIRST];
      end
      if (mode_q[rd_recipe_in] == PCS_MODE_LINEAR) begin
        view_q.min <= lin_min_q[rd_recipe_in];
        view_q.max <= lin_max_q[rd_recipe_in];
        view_q.saved <= lin_saved_q[rd_recipe_in];
      end else begin
        view_q.min <= stp_min_q[rd_recipe_in];
        view_q.max <= stp_max_q[rd_recipe_in];
        view_q.saved <= stp_saved_q[rd_recipe_in];
      end
    end else begin
      view_q <= '0;
    end
  end

  // Checks on the running engine.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_step_hour;
    status_q.on && tick && !stop_in && hour_done && status_q.mode == PCS_MODE_STEPS
      && status_q.hours < PCS_STEP_LAST_W;
  endsequence

  sequence s_lin_end;
    status_q.on && tick && !stop_in && status_q.mode == PCS_MODE_LINEAR
      && mins_nxt >= run_dur_q;
  endsequence

  AST_START_MIN: assert property (start_ok |=> status_q.on && status_q.hours == 8'h00
      && status_q.setpoint == $past(sel_min))
    else $error("start did not load the minimum setpoint");

  AST_START_SAVED: assert property ((start_in && !status_q.on && !sel_saved)
      |=> !status_q.on)
    else $error("start accepted without a saved program");

  AST_LIN_BOUNDS: assert property ((status_q.on && status_q.mode == PCS_MODE_LINEAR)
      |-> status_q.setpoint >= run_min_q && status_q.setpoint < run_max_q)
    else $error("linear setpoint left its span");

  AST_LIN_END: assert property (s_lin_end |=> !status_q.on
      && status_q.setpoint == $past(run_max_q))
    else $error("linear ramp did not end at maximum");

  AST_STEP_ADD: assert property ((s_step_hour ##0 ({1'b0, status_q.setpoint} +
      {1'b0, cur_inc} < {1'b0, run_max_q})) |=> status_q.on
      && status_q.setpoint == $past(status_q.setpoint) + $past(cur_inc))
    else $error("hourly increase not applied");

  AST_STEP_ZERO: assert property ((s_step_hour ##0 cur_inc == '0)
      |=> $stable(status_q.setpoint))
    else $error("zero increase changed the setpoint");

  AST_ON_BELOW_MAX: assert property (status_q.on |-> status_q.setpoint < run_max_q)
    else $error("running setpoint reached maximum without switching off");

  AST_MINUTE_ONLY: assert property ((status_q.on && !tick && !start_ok)
      |=> $stable(status_q.setpoint) && $stable(mins_q))
    else $error("display changed between minute ticks");

  AST_FIRST_HOUR: assert property ((status_q.on && mins_q < PCS_MIN_PER_HOUR_W)
      |-> status_q.hours == 8'h00)
    else $error("elapsed hours nonzero within first hour");

  AST_HOLD_MAX: assert property ((!status_q.on && status_q.setpoint == run_max_q
      && !start_ok) |=> $stable(status_q.setpoint))
    else $error("setpoint left maximum after switching off");

  AST_STOP: assert property ((stop_in && status_q.on) |=> !status_q.on
      && status_q.hours == 8'h00)
    else $error("stop did not clear status and elapsed time");

endmodule : pcs_scheduler

`default_nettype wire

// [test/pcs_scheduler_tb_top.sv]
// Self-checking bench for the pressure compensation scheduler.
// Assumes the design checks its own port timing; the minute is shortened to 8 cycles.
`timescale 1ns/1ns
`default_nettype none

module pcs_scheduler_tb_top;
  import pcs_pkg::*;

  localparam int unsigned CYC = 8;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_wr = 1'b0;
  pcs_cfg_type cfg = '0;
  logic start = 1'b0;
  logic stop = 1'b0;
  pcs_recipe_type run_recipe = 3'h0;
  pcs_recipe_type rd_recipe = 3'h0;
  pcs_hour_type rd_hour = 4'h1;
  pcs_status_type status_s;
  pcs_view_type view_s;
  logic refresh_s;
  int bad_count = 0;
  int checks = 0;
  int k;
  pcs_pres_type steps_exp [4] = '{16'h0064, 16'h0069, 16'h007D, 16'h0096};

  pcs_scheduler #(.CYC_PER_MIN(CYC)) uut (
    .ref_clk_in(ref_clk),
    .reset_n_in(reset_n),
    .cfg_wr_in(cfg_wr),
    .cfg_in(cfg),
    .start_in(start),
    .stop_in(stop),
    .run_recipe_in(run_recipe),
    .rd_recipe_in(rd_recipe),
    .rd_hour_in(rd_hour),
    .status_out(status_s),
    .view_out(view_s),
    .refresh_out(refresh_s)
  );

  // Free running 20 MHz clock.
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // Ends the run with the verdict; also used by the watchdog.
  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Compares a multi-bit value with case equality so unknowns never match.
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  // Compares a single flag.
  task automatic cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag

  // Compares an eight bit hour count without padding it to the pressure width.
  task automatic cmp_hrs(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_hrs

  // One panel write, a single-cycle strobe launched at the falling edge.
  task automatic wr(input pcs_recipe_type r, input pcs_field_type f, input pcs_hour_type h,
                    input pcs_pres_type v);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg = '{recipe: r, field: f, hour: h, value: v};
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask : wr

  // Selects a read back slot; the view lands at the next rising edge, three falling edges give margin.
  task automatic rd(input pcs_recipe_type r, input pcs_hour_type h);
    @(negedge ref_clk);
    rd_recipe = r;
    rd_hour = h;
    repeat (3) @(negedge ref_clk);
  endtask : rd

  // Start or stop pulse; status is settled at the following falling edge.
  task automatic cmd(input logic is_start, input pcs_recipe_type r);
    @(negedge ref_clk);
    start = is_start;
    stop = ~is_start;
    run_recipe = r;
    @(negedge ref_clk);
    start = 1'b0;
    stop = 1'b0;
  endtask : cmd

  // Waits for the next minute refresh pulse under a bound.
  task automatic wait_ref();
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 4 * CYC && refresh_s !== 1'b1; i++) @(negedge ref_clk);
    if (i == 4 * CYC) begin
      cmp_flag(refresh_s, 1'b1);
    end
  endtask : wait_ref

  // Waits for compensation to switch itself off under a bound.
  task automatic wait_off();
    int i;
    for (i = 0; i < 4 * CYC && status_s.on !== 1'b0; i++) @(negedge ref_clk);
  endtask : wait_off

  // Watchdog sized well above the roughly eight thousand three hundred cycles of the tests.
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    cmp_flag(status_s.on, 1'b0);
    cmp_hrs(status_s.hours, 8'h00);
    cmp_val(status_s.setpoint, 16'h0000);
    cmp_val(view_s.min, 16'h0000);
    $display("test reset done");

    // Six recipes hold separate settings; out of range recipes are ignored.
    for (k = 0; k < 6; k++) wr(k[2:0], PCS_FLD_HOURS, 4'h0, 16'h0010 + k[15:0]);
    wr(3'h6, PCS_FLD_HOURS, 4'h0, 16'h00EE);
    wr(3'h7, PCS_FLD_HOURS, 4'h0, 16'h00EE);
    for (k = 0; k < 6; k++) begin
      rd(k[2:0], 4'h1);
      cmp_hrs(view_s.hours, 8'h10 + k[7:0]);
    end
    $display("test recipes done");

    // Linear program; start is refused until saved.
    wr(3'h0, PCS_FLD_MIN, 4'h0, 16'h0064);
    wr(3'h0, PCS_FLD_MAX, 4'h0, 16'h007D);
    wr(3'h0, PCS_FLD_HOURS, 4'h0, 16'h0001);
    cmd(1'b1, 3'h0);
    cmp_flag(status_s.on, 1'b0);
    wr(3'h0, PCS_FLD_MODE, 4'h0, 16'h0001);
    rd(3'h0, 4'h1);
    cmp_flag(view_s.mode, PCS_MODE_STEPS);
    cmp_val(view_s.min, 16'h0000);
    wr(3'h0, PCS_FLD_MODE, 4'h0, 16'h0000);
    rd(3'h0, 4'h1);
    cmp_val(view_s.min, 16'h0064);
    cmp_flag(view_s.saved, 1'b0);
    wr(3'h0, PCS_FLD_SAVE, 4'h0, 16'h0000);
    rd(3'h0, 4'h1);
    cmp_val(view_s.max, 16'h007D);
    cmp_flag(view_s.saved, 1'b1);
    cmd(1'b1, 3'h0);
    cmp_flag(status_s.on, 1'b1);
    cmp_flag(status_s.mode, PCS_MODE_LINEAR);
    cmp_val(status_s.setpoint, 16'h0064);
    for (k = 1; k < 60; k++) begin
      wait_ref();
      cmp_val(status_s.setpoint, 16'h0064 + 16'(25 * k / 60));
      cmp_hrs(status_s.hours, 8'h00);
    end
    wait_off();
    cmp_flag(status_s.on, 1'b0);
    repeat (3 * CYC) @(negedge ref_clk);
    cmp_val(status_s.setpoint, 16'h007D);
    $display("test linear done");

    // Steps program with a zero hour and an overshooting last increase.
    wr(3'h1, PCS_FLD_MODE, 4'h0, 16'h0001);
    wr(3'h1, PCS_FLD_MIN, 4'h0, 16'h0064);
    wr(3'h1, PCS_FLD_MAX, 4'h0, 16'h0096);
    wr(3'h1, PCS_FLD_INC, 4'h1, 16'h0000);
    wr(3'h1, PCS_FLD_INC, 4'h2, 16'h0005);
    wr(3'h1, PCS_FLD_INC, 4'h3, 16'h0014);
    wr(3'h1, PCS_FLD_INC, 4'h4, 16'h001E);
    wr(3'h1, PCS_FLD_SAVE, 4'h0, 16'h0000);
    cmd(1'b1, 3'h1);
    cmp_flag(status_s.mode, PCS_MODE_STEPS);
    cmp_val(status_s.setpoint, 16'h0064);
    for (k = 0; k < 3; k++) begin
      repeat (60) wait_ref();
      cmp_hrs(status_s.hours, 8'(k + 1));
      cmp_val(status_s.setpoint, steps_exp[k]);
    end
    repeat (59) wait_ref();
    wait_off();
    cmp_flag(status_s.on, 1'b0);
    cmp_val(status_s.setpoint, steps_exp[3]);
    $display("test steps done");

    // Hour index outside one to twelve is ignored; short sum stays below maximum.
    wr(3'h2, PCS_FLD_MODE, 4'h0, 16'h0001);
    wr(3'h2, PCS_FLD_INC, 4'h0, 16'h0007);
    wr(3'h2, PCS_FLD_INC, 4'hD, 16'h0007);
    rd(3'h2, 4'h1);
    cmp_val(view_s.inc, 16'h0000);
    rd(3'h2, 4'hC);
    cmp_val(view_s.inc, 16'h0000);
    wr(3'h2, PCS_FLD_MIN, 4'h0, 16'h0064);
    wr(3'h2, PCS_FLD_MAX, 4'h0, 16'h00C8);
    wr(3'h2, PCS_FLD_INC, 4'h1, 16'h000A);
    wr(3'h2, PCS_FLD_INC, 4'hC, 16'h000A);
    wr(3'h2, PCS_FLD_SAVE, 4'h0, 16'h0000);
    cmd(1'b1, 3'h2);
    repeat (60) wait_ref();
    cmd(1'b1, 3'h0);
    cmp_flag(status_s.on, 1'b1);
    cmp_val(status_s.setpoint, 16'h006E);
    repeat (660) wait_ref();
    cmp_hrs(status_s.hours, 8'h0C);
    cmp_val(status_s.setpoint, 16'h0078);
    cmp_flag(status_s.on, 1'b1);
    cmd(1'b0, 3'h2);
    cmp_flag(status_s.on, 1'b0);
    cmp_hrs(status_s.hours, 8'h00);
    cmp_val(status_s.setpoint, 16'h0078);
    cmd(1'b1, 3'h2);
    cmp_hrs(status_s.hours, 8'h00);
    cmp_val(status_s.setpoint, 16'h0064);
    $display("test limits and stop done");
    test_done();
  end
endmodule : pcs_scheduler_tb_top

`default_nettype wire
